// ==== hdl/ascii_drive_frame_slave.sv ====
module ascii_drive_frame_slave #(
   parameter int RX_BYTES  = ascii_frame_pkg::RX_DEPTH,
   parameter int TX_BYTES  = ascii_frame_pkg::TX_DEPTH,
   parameter int MON_WORDS = ascii_frame_pkg::MON_DEPTH
) (
   input  wire logic        clk,       // system clock
   input  wire logic        resetn,    // async reset, active low
   input  wire logic [4:0]  ownDrive,  // configured drive number
   input  wire logic [7:0]  rxByte,    // received character
   input  wire logic        rxValid,   // character strobe
   output logic      [7:0]  txByte,    // answer character
   output logic             txValid,   // answer character valid
   input  wire logic        txReady,   // transmitter takes character
   output logic             parReq,    // parameter access pulse
   output logic             parWrite,  // access is a write
   output logic      [15:0] parAddr,   // parameter address
   output logic      [15:0] parWdata,  // write value
   input  wire logic        parDone,   // access finished
   input  wire logic [1:0]  parErr,    // access error kind
   input  wire logic [15:0] parRdata   // read value
);
   import ascii_frame_pkg::*;

   typedef enum {ST_HUNT, ST_RECV, ST_CHECK, ST_EXEC, ST_WAIT, ST_BUILD, ST_SEND} state_t;
   state_t      state_q;
   logic [7:0]  rxBuf_q [RX_BYTES];
   logic [7:0]  txBuf_q [TX_BYTES];
   logic [15:0] mon_q [MON_WORDS];
   logic [15:0] word_q [MAX_WORDS];
   logic [3:0]  monCnt_q, nWords_q, wIdx_q;
   logic [5:0]  rxCnt_q, bIdx_q, txCnt_q;
   logic [7:0]  drvHi_q, drvLo_q, cmd_q, sum0_q, sum1_q, sum2_q, txSum_q, txByte_q;
   logic [15:0] err_q, parAddr_q, parWdata_q;
   logic        rxOvf_q, nak_q, phase_q, firstWrDone_q, txValid_q, parReq_q, parWrite_q;
   function automatic logic [4:0] hexVal(input logic [7:0] c);
      if (c >= CH_0 && c <= CH_9) return {1'b1, c[3:0]};
      else if (c >= CH_A && c <= CH_F) return {1'b1, c[3:0] + 4'h9};
      else return 5'h00;
   endfunction
   function automatic logic [7:0] hexChar(input logic [3:0] n);
      if (n < NIB_A) return CH_0 | {4'h0, n};
      else return CH_A + {4'h0, n - NIB_A};
   endfunction
   // characters passed in, so continuous users follow every buffer change
   function automatic logic [15:0] bufWord(input logic [7:0] c3, c2, c1, c0);
      logic [4:0] h3, h2, h1, h0;
      h3 = hexVal(c3);
      h2 = hexVal(c2);
      h1 = hexVal(c1);
      h0 = hexVal(c0);
      return {h3[3:0], h2[3:0], h1[3:0], h0[3:0]};
   endfunction
   function automatic logic cntOk(input logic [4:0] v);
      return v[4] && v[3:0] >= N_MIN && v[3:0] <= N_MAX;
   endfunction
   // receive side decode
   wire        rxTake   = rxValid && (state_q == ST_HUNT || state_q == ST_RECV);
   wire        rxStart  = rxTake && rxByte == CH_ENQ;
   wire        rxEnd    = rxTake && state_q == ST_RECV && rxByte == CH_EOT;
   wire        rxData   = rxTake && state_q == ST_RECV && !rxStart && !rxEnd;
   wire [5:0]  bufIdx   = rxCnt_q - HDR_LEN;
   wire        bufFits  = rxCnt_q >= HDR_LEN && 32'(bufIdx) < RX_BYTES;
   wire [5:0]  bodyLen  = rxCnt_q - HDR_LEN;
   wire [4:0]  dHi      = hexVal(drvHi_q);
   wire [4:0]  dLo      = hexVal(drvLo_q);
   wire        drvOk    = rxCnt_q >= HDR_LEN && dHi[4] && dLo[4]
                          && {dHi[3:0], dLo[3:0]} == {3'b000, ownDrive};
   wire        isR      = cmd_q == CMD_READ;
   wire        isW      = cmd_q == CMD_WRITE;
   wire        isX      = cmd_q == CMD_MONSET;
   wire        isY      = cmd_q == CMD_MONGET;
   wire        cmdOk    = isR || isW || isX || isY;
   wire [4:0]  nRw      = hexVal(rxBuf_q[4]);
   wire [4:0]  nMon     = hexVal(rxBuf_q[0]);
   wire [3:0]  nSel     = isX ? nMon[3:0] : nRw[3:0];
   wire [5:0]  expLen   = isR ? R_BODY : isW ? W_BODY_BASE + {nSel, 2'b00}
                          : isX ? X_BODY_BASE + {nSel, 2'b00} : Y_BODY;
   wire        nOk      = isY || (isX ? cntOk(nMon) : cntOk(nRw));
   wire        lenOk    = !rxOvf_q && bodyLen == expLen && nOk;
   wire [5:0]  sumIdx   = lenOk ? bodyLen - 6'h02 : 6'h00;
   wire [4:0]  sHi      = hexVal(rxBuf_q[sumIdx]);
   wire [4:0]  sLo      = hexVal(rxBuf_q[sumIdx + 6'h01]);
   wire        sumOk    = sHi[4] && sLo[4] && {sHi[3:0], sLo[3:0]} == sum2_q;
   wire        frameOk  = lenOk && sumOk;
   wire [15:0] baseAddr = bufWord(rxBuf_q[0], rxBuf_q[1], rxBuf_q[2], rxBuf_q[3]);
   wire [5:0]  wrBase   = 6'h05 + {wIdx_q, 2'b00};
   wire [15:0] wrData   = bufWord(rxBuf_q[wrBase], rxBuf_q[wrBase + 6'h01],
                                  rxBuf_q[wrBase + 6'h02], rxBuf_q[wrBase + 6'h03]);
   // first write: read then write; later: write then read back
   wire        doWrite  = isW && (phase_q == !firstWrDone_q);
   wire        lastWord = wIdx_q == nWords_q - 4'h1;
   wire [15:0] errMap   = parErr == PERR_ADDR ? UNKNOWN_ADDRESS_ERROR
                          : parErr == PERR_RANGE ? VALUE_OUT_OF_RANGE_ERROR
                          : WRITE_FORBIDDEN_ERROR;
   // answer assembly
   wire [5:0]  payLen   = nak_q ? 6'h02 : {nWords_q, 2'b00};
   wire [5:0]  txLen    = nak_q ? NAK_LEN : ACK_BASE + {nWords_q, 2'b00};
   wire [5:0]  pIdx     = bIdx_q - 6'h04;
   wire [15:0] pWord    = word_q[pIdx[4:2]];
   wire [3:0]  pNib     = pWord[4'(4'(3 - pIdx[1:0]) * 4) +: 4];
   wire [7:0]  payByte  = nak_q ? (pIdx[0] ? err_q[7:0] : err_q[15:8]) : hexChar(pNib);
   wire        inPay    = bIdx_q >= 6'h04 && bIdx_q < payLen + 6'h04;
   wire [7:0]  bldByte;
   // start byte, echo, payload, checksum, end byte
   assign bldByte = bIdx_q == 6'h00 ? (nak_q ? CH_NAK : CH_ACK)
                  : bIdx_q == 6'h01 ? drvHi_q
                  : bIdx_q == 6'h02 ? drvLo_q
                  : bIdx_q == 6'h03 ? cmd_q
                  : inPay ? payByte
                  : bIdx_q == payLen + 6'h04 ? hexChar(txSum_q[7:4])
                  : bIdx_q == payLen + 6'h05 ? hexChar(txSum_q[3:0])
                  : CH_EOT;
   wire        bldSum   = bIdx_q >= 6'h01 && bIdx_q < payLen + 6'h04;
   wire        bldLast  = bIdx_q == txLen - 6'h01;
   wire        txAcc    = txValid_q && txReady;
   wire        txLast   = txCnt_q == txLen - 6'h01;
   // bytes arrive one per rxValid strobe; buffer bounded
   always_ff @(posedge clk) begin
      if (rxData && bufFits) rxBuf_q[bufIdx] <= rxByte;
   end
   always_ff @(posedge clk) begin
      if (state_q == ST_BUILD) txBuf_q[bIdx_q] <= bldByte;
   end
   always_ff @(posedge clk) begin
      if (state_q == ST_WAIT && parDone && parErr == PERR_NONE && !doWrite)
         word_q[wIdx_q[2:0]] <= parRdata;
   end
   for (genvar k = 0; k < MON_WORDS; k++) begin : g_mon
      always_ff @(posedge clk) begin
         if (state_q == ST_CHECK && drvOk && isX && frameOk && k < 32'(nSel))
            mon_q[k] <= bufWord(rxBuf_q[1+4*k], rxBuf_q[2+4*k], rxBuf_q[3+4*k], rxBuf_q[4+4*k]);
      end
   end
   // receive framing and checksum pipeline
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxCnt_q <= 6'h00;
         rxOvf_q <= 1'b0;
         sum0_q  <= 8'h00;
         sum1_q  <= 8'h00;
         sum2_q  <= 8'h00;
         drvHi_q <= 8'h00;
         drvLo_q <= 8'h00;
         cmd_q   <= 8'h00;
      // restart on opening byte, sums exclude control bytes
      end else if (rxStart) begin
         rxCnt_q <= 6'h00;
         rxOvf_q <= 1'b0;
         sum0_q  <= 8'h00;
      end else if (rxData) begin
         if (rxCnt_q == 6'h00) drvHi_q <= rxByte;
         if (rxCnt_q == 6'h01) drvLo_q <= rxByte;
         if (rxCnt_q == 6'h02) cmd_q <= rxByte;
         if (rxCnt_q >= HDR_LEN && !bufFits) rxOvf_q <= 1'b1;
         if (rxCnt_q != CNT_MAX) rxCnt_q <= rxCnt_q + 6'h01;
         sum0_q <= sum0_q + rxByte;
         sum1_q <= sum0_q;
         sum2_q <= sum1_q;
      end
   end
   // main sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q       <= ST_HUNT;
         nak_q         <= 1'b0;
         err_q         <= ERR_BADCMD;
         nWords_q      <= 4'h0;
         wIdx_q        <= 4'h0;
         phase_q       <= 1'b0;
         firstWrDone_q <= 1'b0;
         monCnt_q      <= 4'h0;
         parReq_q      <= 1'b0;
         parWrite_q    <= 1'b0;
         parAddr_q     <= 16'h0000;
         parWdata_q    <= 16'h0000;
      end else begin
         parReq_q <= 1'b0;
         unique case (state_q)
            // open on 05h, close on 04h
            ST_HUNT: if (rxStart) state_q <= ST_RECV;
            ST_RECV: if (rxEnd) state_q <= ST_CHECK;
            ST_CHECK: begin
               nak_q    <= 1'b1;
               nWords_q <= 4'h0;
               wIdx_q   <= 4'h0;
               phase_q  <= 1'b0;
               state_q  <= ST_BUILD;
               if (!drvOk) begin
                  state_q <= ST_HUNT;
               end else if (!cmdOk) begin
                  err_q <= ERR_BADCMD;
               end else if (!frameOk) begin
                  err_q <= FRAME_LENGTH_OR_CHECKSUM_ERROR;
               end else if (isX) begin
                  nak_q    <= 1'b0;
                  monCnt_q <= nSel;
               // read or write nSel words, or readback one word per registered address
               end else begin
                  nak_q    <= 1'b0;
                  nWords_q <= isY ? monCnt_q : nSel;
                  if (!isY || monCnt_q != 4'h0) state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               parReq_q   <= 1'b1;
               parWrite_q <= doWrite;
               parAddr_q  <= isY ? mon_q[wIdx_q[2:0]] : baseAddr + {12'h000, wIdx_q};
               parWdata_q <= wrData;
               state_q    <= ST_WAIT;
            end
            ST_WAIT: if (parDone) begin
               if (parErr != PERR_NONE) begin
                  nak_q   <= 1'b1;
                  err_q   <= errMap;
                  state_q <= ST_BUILD;
               end else if (isW && !phase_q) begin
                  phase_q <= 1'b1;
                  state_q <= ST_EXEC;
               end else if (lastWord) begin
                  phase_q <= 1'b0;
                  if (isW) firstWrDone_q <= 1'b1;
                  state_q <= ST_BUILD;
               end else begin
                  phase_q <= 1'b0;
                  wIdx_q  <= wIdx_q + 4'h1;
                  state_q <= ST_EXEC;
               end
            end
            ST_BUILD: if (bldLast) state_q <= ST_SEND;
            ST_SEND: if (txAcc && txLast) state_q <= ST_HUNT;
            default: state_q <= ST_HUNT;
         endcase
      end
   end
   // answer build and transmit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bIdx_q    <= 6'h00;
         txSum_q   <= 8'h00;
         txCnt_q   <= 6'h00;
         txByte_q  <= 8'h00;
         txValid_q <= 1'b0;
      end else if (state_q == ST_BUILD) begin
         // answer checksum over drive, command, payload
         if (bldSum) txSum_q <= txSum_q + bldByte;
         bIdx_q <= bIdx_q + 6'h01;
         if (bldLast) begin
            txByte_q  <= txBuf_q[0];
            txValid_q <= 1'b1;
            txCnt_q   <= 6'h00;
         end
      end else if (state_q == ST_SEND) begin
         if (txAcc) begin
            txValid_q <= !txLast;
            txByte_q  <= txBuf_q[txCnt_q + 6'h01];
            txCnt_q   <= txCnt_q + 6'h01;
         end
      end else begin
         bIdx_q  <= 6'h00;
         txSum_q <= 8'h00;
      end
   end

   assign txByte   = txByte_q;
   assign txValid  = txValid_q;
   assign parReq   = parReq_q;
   assign parWrite = parWrite_q;
   assign parAddr  = parAddr_q;
   assign parWdata = parWdata_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   AST_OPEN_BYTE: assert property (txValid_q && txCnt_q == 6'h00 |->
      txByte_q == (nak_q ? CH_NAK : CH_ACK)) else $error("bad answer start byte");
   AST_CLOSE_BYTE: assert property (txValid_q && txLast |-> txByte_q == CH_EOT)
      else $error("bad answer end byte");
   AST_NAK_NINE: assert property (state_q == ST_SEND && nak_q |-> txLen == NAK_LEN)
      else $error("failure answer not nine bytes");
   AST_ERR_PRINT: assert property (state_q == ST_SEND && nak_q |->
      err_q[15:8] >= PRINT_LO && err_q[7:0] >= PRINT_LO && err_q[15:8] <= PRINT_HI
      && err_q[7:0] <= PRINT_HI) else $error("error code not printable");
   AST_SILENT: assert property (state_q == ST_CHECK && !drvOk |=>
      state_q == ST_HUNT && !txValid_q ##1 !txValid_q) else $error("answered foreign drive");
   AST_RESYNC: assert property (rxStart |=> state_q == ST_RECV && rxCnt_q == 6'h00
      && sum0_q == 8'h00) else $error("no resync on opening byte");
   AST_BADCMD: assert property (state_q == ST_CHECK && drvOk && !cmdOk |=>
      nak_q && err_q == ERR_BADCMD) else $error("bad command not refused");
   AST_MON_LOAD: assert property (state_q == ST_CHECK && drvOk && isX && frameOk |=>
      monCnt_q == $past(nSel) && !nak_q && txLen == ACK_BASE) else $error("monitor load");
   AST_CSUM_FAIL: assert property (state_q == ST_CHECK && drvOk && cmdOk && !sumOk |=>
      nak_q && err_q == FRAME_LENGTH_OR_CHECKSUM_ERROR) else $error("bad sum accepted");
   AST_PAR_WAIT: assert property (parReq_q |-> state_q == ST_WAIT ##1 !parReq_q)
      else $error("parameter request not single");
   AST_FIRST_WR: assert property (parReq_q && isW && !firstWrDone_q |->
      parWrite_q == phase_q) else $error("first write not read first");

   COV_READ_ACK: cover property (state_q == ST_SEND && !nak_q && isR && txLast && txAcc);
   COV_WRITE_ACK: cover property (state_q == ST_SEND && !nak_q && isW && firstWrDone_q);
   COV_NAK: cover property (state_q == ST_SEND && nak_q && txAcc);
   COV_RESYNC: cover property (state_q == ST_RECV && rxCnt_q > 6'h02 && rxStart);
endmodule // ascii_drive_frame_slave

// ==== hdl/ascii_frame_pkg.sv ====
package ascii_frame_pkg;
   // control bytes framing requests and answers
   localparam logic [7:0] CH_ENQ = 8'h05;
   localparam logic [7:0] CH_EOT = 8'h04;
   localparam logic [7:0] CH_ACK = 8'h06;
   localparam logic [7:0] CH_NAK = 8'h15;
   // ascii hex alphabet
   localparam logic [7:0] CH_0   = 8'h30;
   localparam logic [7:0] CH_9   = 8'h39;
   localparam logic [7:0] CH_A   = 8'h41;
   localparam logic [7:0] CH_F   = 8'h46;
   localparam logic [3:0] NIB_A  = 4'hA;
   // command characters
   localparam logic [7:0] CMD_READ   = 8'h52;
   localparam logic [7:0] CMD_WRITE  = 8'h57;
   localparam logic [7:0] CMD_MONSET = 8'h58;
   localparam logic [7:0] CMD_MONGET = 8'h59;
   // two-character failure codes
   localparam logic [15:0] ERR_BADCMD                     = 16'h4946;
   localparam logic [15:0] UNKNOWN_ADDRESS_ERROR          = 16'h4941;
   localparam logic [15:0] VALUE_OUT_OF_RANGE_ERROR       = 16'h4944;
   localparam logic [15:0] WRITE_FORBIDDEN_ERROR          = 16'h574D;
   localparam logic [15:0] FRAME_LENGTH_OR_CHECKSUM_ERROR = 16'h4646;
   localparam logic [7:0]  PRINT_LO = 8'h20;
   localparam logic [7:0]  PRINT_HI = 8'h7F;
   // buffer sizes
   localparam int RX_DEPTH  = 39;
   localparam int TX_DEPTH  = 44;
   localparam int MON_DEPTH = 8;
   localparam int MAX_WORDS = 8;
   // lengths; body counts bytes after drive number and command
   localparam logic [5:0] HDR_LEN     = 6'h03;
   localparam logic [5:0] NAK_LEN     = 6'h09;
   localparam logic [5:0] ACK_BASE    = 6'h07;
   localparam logic [5:0] R_BODY      = 6'h07;
   localparam logic [5:0] W_BODY_BASE = 6'h07;
   localparam logic [5:0] X_BODY_BASE = 6'h03;
   localparam logic [5:0] Y_BODY      = 6'h02;
   localparam logic [5:0] CNT_MAX     = 6'h3F;
   localparam logic [3:0] N_MIN       = 4'h1;
   localparam logic [3:0] N_MAX       = 4'h8;
   // parameter store answers
   localparam logic [1:0] PERR_NONE  = 2'h0;
   localparam logic [1:0] PERR_ADDR  = 2'h1;
   localparam logic [1:0] PERR_RANGE = 2'h2;
endpackage // ascii_frame_pkg

// ==== sim/ascii_drive_frame_slave_tb_top.sv ====
module ascii_drive_frame_slave_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ascii_frame_pkg::*;
   typedef logic [7:0] bytes_t[$];
   logic        clk, resetn, rxValid, txValid, txReady, parReq, parWrite, parDone, firstW;
   logic [4:0]  ownDrive, drv;
   logic [7:0]  rxByte, txByte;
   logic [1:0]  parErr;
   logic [15:0] parAddr, parWdata, parRdata, ra;
   logic [3:0]  rn;
   logic [15:0] mem[256];
   logic [15:0] wd[8];
   logic [15:0] ml[8];
   int          seed = 53364;
   int          nFail, checksDone;
   bytes_t      bd, rq;

   ascii_drive_frame_slave i_ascii_drive_frame_slave (.clk(clk), .resetn(resetn),
      .ownDrive(ownDrive), .rxByte(rxByte), .rxValid(rxValid), .txByte(txByte),
      .txValid(txValid), .txReady(txReady), .parReq(parReq), .parWrite(parWrite),
      .parAddr(parAddr), .parWdata(parWdata), .parDone(parDone), .parErr(parErr),
      .parRdata(parRdata));
   ascii_host_model i_ascii_host_model (.clk(clk), .rxByte(rxByte), .rxValid(rxValid),
      .txByte(txByte), .txValid(txValid), .txReady(txReady));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // parameter store: 256 words, low 16 read-only, values above 7FFF refused
   initial begin
      logic [15:0] pa, pd;
      logic        pw;
      parDone = 1'b0; parErr = PERR_NONE; parRdata = 16'h0000;
      forever begin
         @(negedge clk);
         if (parReq === 1'b1) begin
            pa = parAddr; pw = parWrite; pd = parWdata;
            repeat (1 + ($random(seed) & 3)) @(negedge clk);
            parErr = (pa > 16'h00FF) ? PERR_ADDR : (pw && pa < 16'h0010) ? 2'h3 :
                     (pw && pd > 16'h7FFF) ? PERR_RANGE : PERR_NONE;
            if (parErr == PERR_NONE && pw) mem[pa[7:0]] = pd;
            parRdata = (parErr == PERR_NONE) ? mem[pa[7:0]] : 16'($random(seed));
            parDone = 1'b1;
            @(negedge clk);
            parDone = 1'b0;
            parRdata = ~parRdata;
         end
      end
   end

   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < NIB_A) ? (CH_0 + {4'h0, v}) : (CH_A + {4'h0, v - NIB_A});
   endfunction

   function automatic void w4(input logic [15:0] v);
      for (int i = 3; i >= 0; i--) bd.push_back(hx(v[i*4+:4]));
   endfunction

   // sum over drive, command and data only
   function automatic bytes_t frame(input logic [7:0] lead, cmd, adj);
      bytes_t     f;
      logic [7:0] s;
      f = {lead, hx({3'h0, drv[4]}), hx(drv[3:0]), cmd};
      f = {f, bd};
      s = adj;
      for (int i = 1; i < f.size(); i++) s = s + f[i];
      f = {f, hx(s[7:4]), hx(s[3:0]), CH_EOT};
      return f;
   endfunction

   function automatic bytes_t nak(input logic [7:0] c, input logic [15:0] code);
      bd = {code[15:8], code[7:0]};
      return frame(CH_NAK, c, 8'h00);
   endfunction

   task automatic cmp_frame(input bytes_t e, input bytes_t g);
      checksDone++;
      if (e.size() != g.size()) begin
         nFail++;
         $display("BAD t=%0t exp=%h got=%h", $time, e.size(), g.size());
      end else foreach (e[i]) if (g[i] !== e[i]) begin
         nFail++;
         $display("BAD t=%0t exp=%h got=%h", $time, e[i], g[i]);
         break;
      end
   endtask

   task automatic xfer(input bytes_t req, input bytes_t exp);
      i_ascii_host_model.got.delete();
      i_ascii_host_model.send(req);
      for (int n = 0; n < 900; n++) begin
         @(negedge clk);
         if ((exp.size() > 0 || n >= 60) && txValid === 1'b0 &&
             i_ascii_host_model.got.size() >= exp.size()) break;
      end
      cmp_frame(exp, i_ascii_host_model.got);
   endtask

   task automatic do_read(input logic [15:0] a, input logic [3:0] n);
      logic [15:0] code;
      code = 16'h0000;
      bd = {}; w4(a); bd.push_back(hx(n));
      rq = frame(CH_ENQ, CMD_READ, 8'h00);
      bd = {};
      for (int i = 0; i < n; i++) begin
         if (a + 16'(i) > 16'h00FF) code = UNKNOWN_ADDRESS_ERROR;
         else w4(mem[8'(a + 16'(i))]);
      end
      xfer(rq, code != 16'h0000 ? nak(CMD_READ, code) : frame(CH_ACK, CMD_READ, 8'h00));
   endtask

   task automatic do_write(input logic [15:0] a, input logic [3:0] n);
      logic [15:0] code, aa;
      code = 16'h0000;
      bd = {}; w4(a); bd.push_back(hx(n));
      for (int i = 0; i < n; i++) w4(wd[i]);
      rq = frame(CH_ENQ, CMD_WRITE, 8'h00);
      bd = {};
      for (int i = 0; i < n; i++) begin
         aa = a + 16'(i);
         if (code != 16'h0000) continue;
         if (aa > 16'h00FF) code = UNKNOWN_ADDRESS_ERROR;
         else if (aa < 16'h0010) code = WRITE_FORBIDDEN_ERROR;
         else if (wd[i] > 16'h7FFF) code = VALUE_OUT_OF_RANGE_ERROR;
         else w4(firstW ? mem[aa[7:0]] : wd[i]);
      end
      if (code != 16'h0000) xfer(rq, nak(CMD_WRITE, code));
      else begin
         xfer(rq, frame(CH_ACK, CMD_WRITE, 8'h00));
         firstW = 1'b0;
      end
   endtask

   task automatic do_mon(input logic [3:0] n);
      bd = {}; bd.push_back(hx(n));
      for (int i = 0; i < n; i++) w4(ml[i]);
      rq = frame(CH_ENQ, CMD_MONSET, 8'h00);
      bd = {};
      xfer(rq, frame(CH_ACK, CMD_MONSET, 8'h00));
      rq = frame(CH_ENQ, CMD_MONGET, 8'h00);
      for (int i = 0; i < n; i++) w4(mem[ml[i][7:0]]);
      xfer(rq, frame(CH_ACK, CMD_MONGET, 8'h00));
   endtask

   task automatic conclude;
      if (nFail == 0 && checksDone > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #600000;
      nFail++;
      conclude();
   end

   initial begin
      resetn = 1'b0; ownDrive = 5'h1F; drv = 5'h1F; firstW = 1'b1;
      for (int i = 0; i < 256; i++) mem[i] = 16'($random(seed)) & 16'h7FFF;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      bd = {}; rq = frame(CH_ENQ, CMD_MONGET, 8'h00);
      xfer(rq, frame(CH_ACK, CMD_MONGET, 8'h00));
      do_read(16'h0004, 4'h1);
      do_read(16'h00F8, 4'h8);
      do_read(16'h00FF, 4'h2);
      for (int i = 0; i < 8; i++) wd[i] = 16'($random(seed)) & 16'h7FFF;
      do_write(16'h0008, 4'h1);
      wd[1] = 16'h8000;
      do_write(16'h0020, 4'h2);
      wd[1] = 16'h1234;
      do_write(16'h0030, 4'h8);
      for (int i = 0; i < 8; i++) wd[i] = 16'($random(seed)) & 16'h7FFF;
      do_write(16'h0030, 4'h8);
      for (int i = 0; i < 8; i++) ml[i] = 16'h00F7 - 16'(i * 29);
      do_mon(4'h8);
      do_mon(4'h1);
      for (int k = 0; k < 3; k++) begin
         bd = {}; rq = frame(CH_ENQ, k == 0 ? 8'h5A : k == 1 ? 8'h72 : 8'h51, 8'h00);
         xfer(rq, nak(rq[3], ERR_BADCMD));
      end
      bd = {}; w4(16'h0020); bd.push_back(hx(4'h1));
      rq = frame(CH_ENQ, CMD_READ, 8'h01);
      xfer(rq, nak(CMD_READ, FRAME_LENGTH_OR_CHECKSUM_ERROR));
      bd = {}; w4(16'h0020); bd.push_back(hx(4'h9));
      rq = frame(CH_ENQ, CMD_READ, 8'h00);
      xfer(rq, nak(CMD_READ, FRAME_LENGTH_OR_CHECKSUM_ERROR));
      drv = 5'h01;
      bd = {}; w4(16'h0020); bd.push_back(hx(4'h1));
      rq = frame(CH_ENQ, CMD_READ, 8'h00);
      bd = {};
      xfer(rq, bd);
      drv = 5'h1F;
      i_ascii_host_model.send({CH_ENQ, hx(4'h1), hx(4'hF), CMD_READ, hx(4'h3)});
      do_read(16'h0040, 4'h3);
      i_ascii_host_model.slow = 1'b1;
      for (int r = 0; r < 20; r++) begin
         for (int i = 0; i < 8; i++) wd[i] = 16'($random(seed)) & 16'h7FFF;
         ra = 16'h0010 + 16'($random(seed) & 8'hE7);
         rn = 4'(1 + ($random(seed) & 7));
         if (r % 2 == 0) do_read(ra, rn);
         else do_write(ra, rn);
      end
      conclude();
   end
endmodule // ascii_drive_frame_slave_tb_top

// ==== sim/ascii_host_model.sv ====
module ascii_host_model (
   input  wire logic       clk,      // system clock
   output logic      [7:0] rxByte,   // character to the slave
   output logic            rxValid,  // character strobe
   input  wire logic [7:0] txByte,   // answer character
   input  wire logic       txValid,  // answer offered
   output logic            txReady   // answer taken
);
   timeunit 1ns;
   timeprecision 1ps;
   int         hseed = 53364;
   logic       slow;
   logic [7:0] got[$];

   initial begin
      rxByte  = 8'hA5;
      rxValid = 1'b0;
      txReady = 1'b0;
      slow    = 1'b0;
   end

   // stalls the answer at random in slow mode
   always @(negedge clk) begin
      txReady <= slow ? (($random(hseed) & 3) == 0) : 1'b1;
   end

   always @(posedge clk) begin
      if (txValid === 1'b1 && txReady === 1'b1) begin
         got.push_back(txByte);
      end
   end

   task automatic send(input logic [7:0] f[$]);
      foreach (f[i]) begin
         @(negedge clk);
         rxByte  = f[i];
         rxValid = 1'b1;
         @(negedge clk);
         rxValid = 1'b0;
         rxByte  = ~f[i];
      end
   endtask
endmodule // ascii_host_model
